// File: bbx_pkg.sv
// Constants and operation codes for the bit and branch execution unit.
// Assumes a decoder ahead of it that supplies one operation per valid cycle.
package bbx_pkg;
   localparam int PC_W = 16;
   localparam int PAGE_W = 11;
   localparam int BYTE_W = 8;
   localparam int BIT_ADDR_W = 8;
   localparam int BIT_SEL_W = 3;
   localparam int BIT_AREA_MSB = 7;
   localparam logic [3:0] BIT_RAM_BASE_HI = 4'h2;
   localparam logic [7:0] BIT_SFR_MASK = 8'hF8;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;

   typedef enum logic [5:0] {
      OP_IDLE,
      OP_CLEAR_CARRY,
      OP_CLEAR_BIT,
      OP_FORCE_CARRY,
      OP_FORCE_BIT,
      OP_INVERT_CARRY,
      OP_INVERT_BIT,
      OP_AND_BIT,
      OP_AND_NBIT,
      OP_OR_BIT,
      OP_OR_NBIT,
      OP_BIT_TO_CARRY,
      OP_CARRY_TO_BIT,
      OP_PAGE_CALL,
      OP_FAR_CALL,
      OP_SUB_EXIT,
      OP_INT_EXIT,
      OP_PAGE_JUMP,
      OP_FAR_JUMP,
      OP_SHORT_JUMP,
      OP_IND_BRANCH,
      OP_ACC_ZERO,
      OP_ACC_NONZERO,
      OP_CARRY_SET,
      OP_CARRY_CLEAR,
      OP_BIT_SET,
      OP_BIT_CLEAR,
      OP_BIT_TEST_CLEAR,
      OP_CMP_ACC_BYTE,
      OP_CMP_ACC_IMM,
      OP_CMP_OPND_IMM,
      OP_DEC_BANK,
      OP_DEC_BYTE
   } bbx_op_t;
endpackage

// File: bbx_exec.sv
// Execution unit for bit manipulation and program branch operations.
// Assumes operands are fetched by the caller in the cycle of EXEC_VALID,
// and that the popped stack word is already on STACK_PC for exits.
`timescale 1ns/10ps
module bbx_exec (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Operation
   input wire logic EXEC_VALID,
   input bbx_pkg::bbx_op_t EXEC_OP,
   // Operands
   input wire logic [15:0] PC_NEXT,
   input wire logic [7:0] REL_OFFSET,
   input wire logic [10:0] PAGE_TARGET,
   input wire logic [15:0] FULL_TARGET,
   input wire logic [7:0] ACC,
   input wire logic [15:0] DATA_POINTER,
   input wire logic CARRY_IN,
   input wire logic [7:0] BIT_ADDR,
   input wire logic BIT_IN,
   input wire logic [7:0] BYTE_IN,
   input wire logic [7:0] IMM_BYTE,
   input wire logic [15:0] STACK_PC,
   // Results
   output logic DONE,
   output logic CARRY_WE,
   output logic CARRY_OUT,
   output logic BIT_WE,
   output logic BIT_IS_SFR,
   output logic [7:0] BIT_BYTE_ADDR,
   output logic [2:0] BIT_INDEX,
   output logic BIT_OUT,
   output logic BYTE_WE,
   output logic [7:0] BYTE_OUT,
   output logic PC_LOAD,
   output logic [15:0] PC_TARGET,
   output logic PUSH_REQ,
   output logic [15:0] PUSH_PC,
   output logic POP_REQ,
   output logic PRIO_RELEASE
);
   logic carry_we_d, carry_d, bit_we_d, bit_d, byte_we_d, pc_load_d, push_d, pop_d, release_d;
   logic [7:0] byte_d, dec_val, bit_byte_d;
   logic [15:0] pc_target_d, rel_ext, rel_target, page_target_full, ind_target;
   // Sign extension keeps the reach to +127/-128
   assign rel_ext = {{(bbx_pkg::PC_W - bbx_pkg::BYTE_W){REL_OFFSET[7]}}, REL_OFFSET};
   assign rel_target = PC_NEXT + rel_ext;
   assign page_target_full = {PC_NEXT[15:bbx_pkg::PAGE_W], PAGE_TARGET};
   assign ind_target = DATA_POINTER + {8'h00, ACC};
   assign dec_val = BYTE_IN - bbx_pkg::BYTE_ONE;
   // Low half of bit space maps onto RAM bytes, upper half onto SFR bytes
   assign bit_byte_d = BIT_ADDR[bbx_pkg::BIT_AREA_MSB] ? (BIT_ADDR & bbx_pkg::BIT_SFR_MASK)
      : {bbx_pkg::BIT_RAM_BASE_HI, BIT_ADDR[bbx_pkg::BIT_AREA_MSB-1:bbx_pkg::BIT_SEL_W]};

   always_comb begin
      carry_we_d = 1'b0;
      carry_d = CARRY_IN;
      bit_we_d = 1'b0;
      bit_d = BIT_IN;
      byte_we_d = 1'b0;
      byte_d = BYTE_IN;
      pc_load_d = 1'b0;
      pc_target_d = rel_target;
      push_d = 1'b0;
      pop_d = 1'b0;
      release_d = 1'b0;
      unique case (EXEC_OP)
         bbx_pkg::OP_IDLE: carry_we_d = 1'b0;
         bbx_pkg::OP_CLEAR_CARRY: begin
            carry_we_d = 1'b1;
            carry_d = 1'b0;
         end
         bbx_pkg::OP_CLEAR_BIT: begin
            bit_we_d = 1'b1;
            bit_d = 1'b0;
         end
         bbx_pkg::OP_FORCE_CARRY: begin
            carry_we_d = 1'b1;
            carry_d = 1'b1;
         end
         bbx_pkg::OP_FORCE_BIT: begin
            bit_we_d = 1'b1;
            bit_d = 1'b1;
         end
         bbx_pkg::OP_INVERT_CARRY: begin
            carry_we_d = 1'b1;
            carry_d = ~CARRY_IN;
         end
         bbx_pkg::OP_INVERT_BIT: begin
            bit_we_d = 1'b1;
            bit_d = ~BIT_IN;
         end
         bbx_pkg::OP_AND_BIT: begin
            carry_we_d = 1'b1;
            carry_d = CARRY_IN & BIT_IN;
         end
         bbx_pkg::OP_AND_NBIT: begin
            carry_we_d = 1'b1;
            carry_d = CARRY_IN & ~BIT_IN;
         end
         bbx_pkg::OP_OR_BIT: begin
            carry_we_d = 1'b1;
            carry_d = CARRY_IN | BIT_IN;
         end
         bbx_pkg::OP_OR_NBIT: begin
            carry_we_d = 1'b1;
            carry_d = CARRY_IN | ~BIT_IN;
         end
         bbx_pkg::OP_BIT_TO_CARRY: begin
            carry_we_d = 1'b1;
            carry_d = BIT_IN;
         end
         bbx_pkg::OP_CARRY_TO_BIT: begin
            bit_we_d = 1'b1;
            bit_d = CARRY_IN;
         end
         bbx_pkg::OP_PAGE_CALL: begin
            push_d = 1'b1;
            pc_load_d = 1'b1;
            pc_target_d = page_target_full;
         end
         bbx_pkg::OP_FAR_CALL: begin
            push_d = 1'b1;
            pc_load_d = 1'b1;
            pc_target_d = FULL_TARGET;
         end
         bbx_pkg::OP_SUB_EXIT: begin
            pop_d = 1'b1;
            pc_load_d = 1'b1;
            pc_target_d = STACK_PC;
         end
         bbx_pkg::OP_INT_EXIT: begin
            pop_d = 1'b1;
            release_d = 1'b1;
            pc_load_d = 1'b1;
            pc_target_d = STACK_PC;
         end
         bbx_pkg::OP_PAGE_JUMP: begin
            pc_load_d = 1'b1;
            pc_target_d = page_target_full;
         end
         bbx_pkg::OP_FAR_JUMP: begin
            pc_load_d = 1'b1;
            pc_target_d = FULL_TARGET;
         end
         bbx_pkg::OP_SHORT_JUMP: pc_load_d = 1'b1;
         bbx_pkg::OP_IND_BRANCH: begin
            pc_load_d = 1'b1;
            pc_target_d = ind_target;
         end
         bbx_pkg::OP_ACC_ZERO: pc_load_d = (ACC == bbx_pkg::BYTE_ZERO);
         bbx_pkg::OP_ACC_NONZERO: pc_load_d = (ACC != bbx_pkg::BYTE_ZERO);
         bbx_pkg::OP_CARRY_SET: pc_load_d = CARRY_IN;
         bbx_pkg::OP_CARRY_CLEAR: pc_load_d = ~CARRY_IN;
         bbx_pkg::OP_BIT_SET: pc_load_d = BIT_IN;
         bbx_pkg::OP_BIT_CLEAR: pc_load_d = ~BIT_IN;
         bbx_pkg::OP_BIT_TEST_CLEAR: begin
            pc_load_d = BIT_IN;
            bit_we_d = BIT_IN;
            bit_d = 1'b0;
         end
         // Carry flags "less than" as a side effect of the compare
         bbx_pkg::OP_CMP_ACC_BYTE: begin
            pc_load_d = (ACC != BYTE_IN);
            carry_we_d = 1'b1;
            carry_d = (ACC < BYTE_IN);
         end
         bbx_pkg::OP_CMP_ACC_IMM: begin
            pc_load_d = (ACC != IMM_BYTE);
            carry_we_d = 1'b1;
            carry_d = (ACC < IMM_BYTE);
         end
         bbx_pkg::OP_CMP_OPND_IMM: begin
            pc_load_d = (BYTE_IN != IMM_BYTE);
            carry_we_d = 1'b1;
            carry_d = (BYTE_IN < IMM_BYTE);
         end
         bbx_pkg::OP_DEC_BANK, bbx_pkg::OP_DEC_BYTE: begin
            byte_we_d = 1'b1;
            byte_d = dec_val;
            pc_load_d = (dec_val != bbx_pkg::BYTE_ZERO);
         end
         default: ; // Unused codes of the field act as idle
      endcase
   end

   // Completion strobe, one per accepted operation
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         DONE <= 1'b0;
      end else begin
         DONE <= EXEC_VALID;
      end
   end

   // Carry update
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         CARRY_WE <= 1'b0;
         CARRY_OUT <= 1'b0;
      end else begin
         CARRY_WE <= EXEC_VALID & carry_we_d;
         CARRY_OUT <= carry_d;
      end
   end

   // Bit write-back; address is resolved even when no write follows
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         BIT_WE <= 1'b0;
         BIT_OUT <= 1'b0;
         BIT_IS_SFR <= 1'b0;
         BIT_BYTE_ADDR <= bbx_pkg::BYTE_ZERO;
         BIT_INDEX <= '0;
      end else begin
         BIT_WE <= EXEC_VALID & bit_we_d;
         BIT_OUT <= bit_d;
         BIT_IS_SFR <= BIT_ADDR[bbx_pkg::BIT_AREA_MSB];
         BIT_BYTE_ADDR <= bit_byte_d;
         BIT_INDEX <= BIT_ADDR[bbx_pkg::BIT_SEL_W-1:0];
      end
   end

   // Byte write-back for decrement-and-branch
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         BYTE_WE <= 1'b0;
         BYTE_OUT <= bbx_pkg::BYTE_ZERO;
      end else begin
         BYTE_WE <= EXEC_VALID & byte_we_d;
         BYTE_OUT <= byte_d;
      end
   end

   // Program counter redirect
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         PC_LOAD <= 1'b0;
         PC_TARGET <= bbx_pkg::PC_RESET;
      end else begin
         PC_LOAD <= EXEC_VALID & pc_load_d;
         PC_TARGET <= pc_target_d;
      end
   end

   // Stack and interrupt-level requests
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         PUSH_REQ <= 1'b0;
         PUSH_PC <= bbx_pkg::PC_RESET;
         POP_REQ <= 1'b0;
         PRIO_RELEASE <= 1'b0;
      end else begin
         PUSH_REQ <= EXEC_VALID & push_d;
         PUSH_PC <= PC_NEXT;
         POP_REQ <= EXEC_VALID & pop_d;
         PRIO_RELEASE <= EXEC_VALID & release_d;
      end
   end

   property p_clear_carry;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_CLEAR_CARRY) |=> (CARRY_WE && !CARRY_OUT);
   endproperty
   a_clear_carry: assert property (p_clear_carry)
      else $error("carry not cleared");
   property p_invert_bit;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_INVERT_BIT)
         |=> (BIT_WE && BIT_OUT == !$past(BIT_IN) && !CARRY_WE);
   endproperty
   a_invert_bit: assert property (p_invert_bit)
      else $error("bit not inverted");
   property p_and_nbit;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_AND_NBIT)
         |=> (CARRY_WE && !BIT_WE && CARRY_OUT == ($past(CARRY_IN) && !$past(BIT_IN)));
   endproperty
   a_and_nbit: assert property (p_and_nbit)
      else $error("carry and inverted bit wrong");
   property p_short_jump;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_SHORT_JUMP)
         |=> (PC_LOAD && PC_TARGET == $past(PC_NEXT) + 16'(signed'($past(REL_OFFSET))));
   endproperty
   a_short_jump: assert property (p_short_jump)
      else $error("short jump target wrong");
   property p_page_same;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && (EXEC_OP == bbx_pkg::OP_PAGE_JUMP || EXEC_OP == bbx_pkg::OP_PAGE_CALL))
         |=> (PC_LOAD && PC_TARGET[15:11] == $past(PC_NEXT[15:11])
              && PC_TARGET[10:0] == $past(PAGE_TARGET));
   endproperty
   a_page_same: assert property (p_page_same)
      else $error("page target left its page");
   property p_bit_test_clear;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_BIT_TEST_CLEAR)
         |=> (PC_LOAD == $past(BIT_IN) && BIT_WE == $past(BIT_IN) && !BIT_OUT);
   endproperty
   a_bit_test_clear: assert property (p_bit_test_clear)
      else $error("test and clear mismatch");
   property p_compare;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_CMP_OPND_IMM)
         |=> (PC_LOAD == ($past(BYTE_IN) != $past(IMM_BYTE)));
   endproperty
   a_compare: assert property (p_compare)
      else $error("compare branch wrong");
   property p_decrement;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_DEC_BANK)
         |=> (BYTE_WE && BYTE_OUT == ($past(BYTE_IN) - 8'h01) && PC_LOAD == (BYTE_OUT != 8'h00));
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("decrement branch wrong");
   property p_idle;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_IDLE)
         |=> (DONE && !PC_LOAD && !CARRY_WE && !BIT_WE && !BYTE_WE && !PUSH_REQ && !POP_REQ);
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle changed state");
   property p_call_push;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_FAR_CALL)
         |=> (PUSH_REQ && PUSH_PC == $past(PC_NEXT) && PC_TARGET == $past(FULL_TARGET));
   endproperty
   a_call_push: assert property (p_call_push)
      else $error("call did not push return");
   property p_int_exit;
      @(posedge CLK) disable iff (!RSTN)
      (EXEC_VALID && EXEC_OP == bbx_pkg::OP_INT_EXIT)
         |=> (PRIO_RELEASE && POP_REQ && PC_LOAD && PC_TARGET == $past(STACK_PC));
   endproperty
   a_int_exit: assert property (p_int_exit)
      else $error("interrupt exit incomplete");
endmodule // bbx_exec

// File: bbx_exec_tb.sv
// Self-checking bench for the bit and branch execution unit.
// Assumes bbx_pkg and bbx_exec are compiled first; drives every operand itself.
`timescale 1ns/10ps
module bbx_exec_tb;
   typedef struct {
      int due;
      logic [1:0] cw;
      logic [1:0] bw;
      logic [8:0] yw;
      logic [16:0] pc;
      logic [16:0] pu;
      logic pop;
      logic prio;
      logic sfr;
      logic [7:0] badr;
      logic [2:0] bidx;
   } bbx_note_t;

   // Design inputs
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic EXEC_VALID = 1'b0;
   bbx_pkg::bbx_op_t EXEC_OP = bbx_pkg::OP_IDLE;
   logic [15:0] PC_NEXT = 16'h0000;
   logic [7:0] REL_OFFSET = 8'h00;
   logic [10:0] PAGE_TARGET = 11'h000;
   logic [15:0] FULL_TARGET = 16'h0000;
   logic [7:0] ACC = 8'h00;
   logic [15:0] DATA_POINTER = 16'h0000;
   logic CARRY_IN = 1'b0;
   logic [7:0] BIT_ADDR = 8'h00;
   logic BIT_IN = 1'b0;
   logic [7:0] BYTE_IN = 8'h00;
   logic [7:0] IMM_BYTE = 8'h00;
   logic [15:0] STACK_PC = 16'h0000;
   // Design outputs
   logic DONE, CARRY_WE, CARRY_OUT, BIT_WE, BIT_IS_SFR, BIT_OUT, BYTE_WE;
   logic PC_LOAD, PUSH_REQ, POP_REQ, PRIO_RELEASE;
   logic [7:0] BIT_BYTE_ADDR, BYTE_OUT;
   logic [2:0] BIT_INDEX;
   logic [15:0] PC_TARGET, PUSH_PC;

   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   integer seed = 32'hE6CA96DD;
   bbx_note_t notes[$];
   logic [15:0] o_pc, o_ft, o_dp, o_st;
   logic [10:0] o_pt;
   logic [7:0] o_rel, o_acc, o_ba, o_by, o_imm;
   logic o_c, o_b;

   bbx_exec dut_u (
      .CLK(CLK), .RSTN(RSTN), .EXEC_VALID(EXEC_VALID), .EXEC_OP(EXEC_OP),
      .PC_NEXT(PC_NEXT), .REL_OFFSET(REL_OFFSET), .PAGE_TARGET(PAGE_TARGET),
      .FULL_TARGET(FULL_TARGET), .ACC(ACC), .DATA_POINTER(DATA_POINTER),
      .CARRY_IN(CARRY_IN), .BIT_ADDR(BIT_ADDR), .BIT_IN(BIT_IN), .BYTE_IN(BYTE_IN),
      .IMM_BYTE(IMM_BYTE), .STACK_PC(STACK_PC), .DONE(DONE), .CARRY_WE(CARRY_WE),
      .CARRY_OUT(CARRY_OUT), .BIT_WE(BIT_WE), .BIT_IS_SFR(BIT_IS_SFR),
      .BIT_BYTE_ADDR(BIT_BYTE_ADDR), .BIT_INDEX(BIT_INDEX), .BIT_OUT(BIT_OUT),
      .BYTE_WE(BYTE_WE), .BYTE_OUT(BYTE_OUT), .PC_LOAD(PC_LOAD), .PC_TARGET(PC_TARGET),
      .PUSH_REQ(PUSH_REQ), .PUSH_PC(PUSH_PC), .POP_REQ(POP_REQ),
      .PRIO_RELEASE(PRIO_RELEASE)
   );

   always #12.5 CLK = ~CLK;

   task automatic results();
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Run is about 700 cycles; ceiling leaves wide margin
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         $display("Error at %0t: timeout", $time);
         results();
      end
   end

   task automatic rnd();
      o_pc = 16'($random(seed));
      o_ft = 16'($random(seed));
      o_dp = 16'($random(seed));
      o_st = 16'($random(seed));
      o_pt = 11'($random(seed));
      o_rel = 8'($random(seed));
      o_acc = 8'($random(seed));
      o_ba = 8'($random(seed));
      o_by = 8'($random(seed));
      o_imm = 8'($random(seed));
      o_c = 1'($random(seed));
      o_b = 1'($random(seed));
   endtask

   // Boundary operands: zero acc, equal compares, wrap, page edge
   task automatic corner(input int i);
      case (i)
         0: begin
            o_acc = 8'h00;
            o_by = 8'h01;
            o_imm = 8'h01;
            o_rel = 8'h80;
            o_b = 1'b1;
            o_c = 1'b0;
            o_ba = 8'h7F;
         end
         1: begin
            o_by = o_acc;
            o_imm = o_acc;
            o_rel = 8'h7F;
            o_b = 1'b0;
            o_c = 1'b1;
            o_ba = 8'h80;
         end
         2: begin
            o_by = 8'h00;
            o_acc = 8'hFF;
            o_dp = 16'hFFFF;
            o_pc = 16'hF7FF;
            o_pt = 11'h7FF;
         end
         default: ;
      endcase
   endtask

   function automatic bbx_note_t model(input bbx_pkg::bbx_op_t op);
      bbx_note_t n;
      logic [15:0] rt;
      logic [7:0] dec;
      n = '{default: '0};
      rt = o_pc + {{8{o_rel[7]}}, o_rel};
      dec = o_by - 8'h01;
      n.sfr = o_ba[7];
      n.badr = o_ba[7] ? (o_ba & 8'hF8) : {4'h2, o_ba[6:3]};
      n.bidx = o_ba[2:0];
      case (op)
         bbx_pkg::OP_CLEAR_CARRY: n.cw = 2'b10;
         bbx_pkg::OP_CLEAR_BIT: n.bw = 2'b10;
         bbx_pkg::OP_FORCE_CARRY: n.cw = 2'b11;
         bbx_pkg::OP_FORCE_BIT: n.bw = 2'b11;
         bbx_pkg::OP_INVERT_CARRY: n.cw = {1'b1, ~o_c};
         bbx_pkg::OP_INVERT_BIT: n.bw = {1'b1, ~o_b};
         bbx_pkg::OP_AND_BIT: n.cw = {1'b1, o_c & o_b};
         bbx_pkg::OP_AND_NBIT: n.cw = {1'b1, o_c & ~o_b};
         bbx_pkg::OP_OR_BIT: n.cw = {1'b1, o_c | o_b};
         bbx_pkg::OP_OR_NBIT: n.cw = {1'b1, o_c | ~o_b};
         bbx_pkg::OP_BIT_TO_CARRY: n.cw = {1'b1, o_b};
         bbx_pkg::OP_CARRY_TO_BIT: n.bw = {1'b1, o_c};
         bbx_pkg::OP_PAGE_CALL, bbx_pkg::OP_FAR_CALL: begin
            n.pu = {1'b1, o_pc};
            n.pc = (op == bbx_pkg::OP_FAR_CALL) ? {1'b1, o_ft} : {1'b1, o_pc[15:11], o_pt};
         end
         bbx_pkg::OP_SUB_EXIT, bbx_pkg::OP_INT_EXIT: begin
            n.pc = {1'b1, o_st};
            n.pop = 1'b1;
            n.prio = (op == bbx_pkg::OP_INT_EXIT);
         end
         bbx_pkg::OP_PAGE_JUMP: n.pc = {1'b1, o_pc[15:11], o_pt};
         bbx_pkg::OP_FAR_JUMP: n.pc = {1'b1, o_ft};
         bbx_pkg::OP_SHORT_JUMP: n.pc = {1'b1, rt};
         bbx_pkg::OP_IND_BRANCH: n.pc = {1'b1, o_dp + {8'h00, o_acc}};
         bbx_pkg::OP_ACC_ZERO: n.pc = {o_acc == 8'h00, rt};
         bbx_pkg::OP_ACC_NONZERO: n.pc = {o_acc != 8'h00, rt};
         bbx_pkg::OP_CARRY_SET: n.pc = {o_c, rt};
         bbx_pkg::OP_CARRY_CLEAR: n.pc = {~o_c, rt};
         bbx_pkg::OP_BIT_SET: n.pc = {o_b, rt};
         bbx_pkg::OP_BIT_CLEAR: n.pc = {~o_b, rt};
         bbx_pkg::OP_BIT_TEST_CLEAR: begin
            n.pc = {o_b, rt};
            n.bw = {o_b, 1'b0};
         end
         bbx_pkg::OP_CMP_ACC_BYTE: begin
            n.pc = {o_acc != o_by, rt};
            n.cw = {1'b1, o_acc < o_by};
         end
         bbx_pkg::OP_CMP_ACC_IMM: begin
            n.pc = {o_acc != o_imm, rt};
            n.cw = {1'b1, o_acc < o_imm};
         end
         bbx_pkg::OP_CMP_OPND_IMM: begin
            n.pc = {o_by != o_imm, rt};
            n.cw = {1'b1, o_by < o_imm};
         end
         bbx_pkg::OP_DEC_BANK, bbx_pkg::OP_DEC_BYTE: begin
            n.yw = {1'b1, dec};
            n.pc = {dec != 8'h00, rt};
         end
         default: ;
      endcase
      return n;
   endfunction

   task automatic send(input bbx_pkg::bbx_op_t op);
      bbx_note_t n;
      @(posedge CLK);
      EXEC_VALID <= 1'b1;
      EXEC_OP <= op;
      PC_NEXT <= o_pc;
      REL_OFFSET <= o_rel;
      PAGE_TARGET <= o_pt;
      FULL_TARGET <= o_ft;
      ACC <= o_acc;
      DATA_POINTER <= o_dp;
      CARRY_IN <= o_c;
      BIT_ADDR <= o_ba;
      BIT_IN <= o_b;
      BYTE_IN <= o_by;
      IMM_BYTE <= o_imm;
      STACK_PC <= o_st;
      n = model(op);
      n.due = cyc + 2;
      notes.push_back(n);
   endtask

   // A call code with valid low must stay silent
   task automatic idle();
      @(posedge CLK);
      EXEC_VALID <= 1'b0;
      EXEC_OP <= bbx_pkg::OP_FAR_CALL;
   endtask

   always @(posedge CLK) begin
      bbx_note_t n;
      if (cyc > 1) begin
         if (DONE === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            chk(17'(cyc), 17'(n.due));
            chk(CARRY_WE, n.cw[1]);
            if (n.cw[1]) chk(CARRY_OUT, n.cw[0]);
            chk(BIT_WE, n.bw[1]);
            if (n.bw[1]) chk(BIT_OUT, n.bw[0]);
            chk({BIT_IS_SFR, BIT_BYTE_ADDR, BIT_INDEX}, {n.sfr, n.badr, n.bidx});
            chk(BYTE_WE, n.yw[8]);
            if (n.yw[8]) chk(BYTE_OUT, n.yw[7:0]);
            chk(PC_LOAD, n.pc[16]);
            if (n.pc[16]) chk(PC_TARGET, n.pc[15:0]);
            chk(PUSH_REQ, n.pu[16]);
            if (n.pu[16]) chk(PUSH_PC, n.pu[15:0]);
            chk({POP_REQ, PRIO_RELEASE}, {n.pop, n.prio});
         end else begin
            chk({DONE, CARRY_WE, BIT_WE, BYTE_WE, PC_LOAD, PUSH_REQ, POP_REQ}, 17'h0);
            chk(PRIO_RELEASE, 1'b0);
         end
      end
   end

   initial begin
      repeat (16) @(posedge CLK);
      RSTN <= 1'b1;
      repeat (2) @(posedge CLK);
      // First pass back to back, second with random gaps
      for (int pass = 0; pass < 2; pass++) begin
         for (int k = 0; k <= 32; k++) begin
            for (int i = 0; i < 8; i++) begin
               rnd();
               corner(i);
               send(bbx_pkg::bbx_op_t'(k));
               if (pass == 1 && ($random(seed) & 1)) idle();
            end
         end
      end
      idle();
      repeat (3) @(posedge CLK);
      chk(17'(notes.size()), 17'h0);
      results();
   end
endmodule // bbx_exec_tb
